// file: sim/dtlc_bench.sv
// Self-checking bench for the mode-register configuration block.
// Assumes x16 defaults, a 40 ns core clock and an 80 ns link clock.
`timescale 1ns/100ps
module dtlc_bench;
  import dtlc_pkg::*;
  logic clk_in = 1'h0, lk = 1'h0, rst_n = 1'h0, tc = 1'h0, wa = 1'h0, cv = 1'h0, cw = 1'h0;
  logic cvo, cwo, mv;
  dtlc_mrs_t mrs;
  dtlc_status_t st;
  int fails = 0, checked = 0, cyc = 0;
  always #20 clk_in = ~clk_in;
  initial begin
    #7;
    forever #40 lk = ~lk;
  end
  dtlc_top dut (.clk_in(clk_in), .rst_n_in(rst_n), .ce_in(1'h1), .link_clk_in(lk),
    .link_rst_n_in(rst_n), .mrs_in(mrs), .mrs_valid_in(mv), .on_die_termination_control_in(tc),
    .write_active_in(wa), .cmd_valid_in(cv), .cmd_write_in(cw), .cmd_valid_out(cvo),
    .cmd_write_out(cwo), .status_out(st));
  dtlc_ctrl_model ctrl (.link_clk_in(lk), .mrs_out(mrs), .mrs_valid_out(mv));
  task automatic chk(input logic ok, input string what);
    checked++;
    if (ok !== 1'h1) begin
      fails++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wt
  task automatic give_verdict;
    $display("checked %0d, fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic t_drive;
    // Additive latency code 1 (read column latency minus 1) is requested on purpose; the x16 part must ignore it
    ctrl.send(3'h1, 18'h0_138C);
    wt(10);
    tc <= 1'h1;
    wt(3);
    chk(st.drive_imp === 2'h2, "impedance");
    chk(st.outputs_off === 1'h1, "outputs off");
    chk(st.leveling_on === 1'h1, "leveling");
    chk(st.read_latency_total === 6'h09, "read latency");
    chk(st.termination_source === DTLC_APPLY_NOM && st.termination_code === 3'h3, "nominal");
    ctrl.send(3'h1, 18'h0_038C);
    wt(10);
    chk(st.outputs_off === 1'h0, "outputs on");
    $display("drive test done");
  endtask : t_drive
  task automatic t_wlat;
    logic [2:0] term;
    int wcl [8] = '{9, 10, 11, 12, 14, 16, 18, 20};
    wa <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      term = (i < 5) ? 3'(i) : 3'h0;
      ctrl.send(3'h2, {5'h00, 1'h1, term, 1'h0, 2'h2, 3'(i), 3'h0});
      wt(10);
      chk(st.write_latency_total === 6'(wcl[i]), "write latency");
      chk(st.write_crc_on === 1'h1 && st.low_power_self_refresh_range === 2'h2, "crc");
      chk(term == 3'h0 ? st.termination_source === DTLC_APPLY_NOM : st.termination_source ===
        DTLC_APPLY_WR && st.termination_code === term, "write termination");
    end
    $display("write latency test done");
  endtask : t_wlat
  task automatic t_park;
    ctrl.send(3'h5, 18'h0_0140);
    wt(10);
    ctrl.send(3'h3, 18'h0_0080);
    wt(10);
    tc <= 1'h0;
    wa <= 1'h0;
    wt(3);
    chk(st.termination_source === DTLC_APPLY_PARK && st.termination_code === 3'h5, "park");
    $display("park test done");
  endtask : t_park
  task automatic t_cmd;
    cv <= 1'h1;
    cw <= 1'h1;
    @(posedge clk_in);
    cw <= 1'h0;
    @(negedge clk_in);
    chk(cvo === 1'h1 && cwo === 1'h1, "write delay");
    @(posedge clk_in);
    cv <= 1'h0;
    @(negedge clk_in);
    chk(cvo === 1'h1 && cwo === 1'h0, "read delay");
    @(negedge clk_in);
    chk(cvo === 1'h0, "single pulse");
    $display("command test done");
  endtask : t_cmd
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      give_verdict;
    end
  end
  initial begin
    wt(12);
    rst_n <= 1'h1;
    wt(2);
    t_drive;
    t_wlat;
    t_park;
    t_cmd;
    give_verdict;
  end
endmodule : dtlc_bench

// file: sim/dtlc_ctrl_model.sv
// Controller model issuing mode register set commands on the link clock.
// Assumes callers start only after the link reset is released.
`timescale 1ns/100ps
module dtlc_ctrl_model import dtlc_pkg::*; (
  input  wire logic link_clk_in,
  output dtlc_mrs_t mrs_out,
  output logic      mrs_valid_out
);
  initial begin
    mrs_out = '0;
    mrs_valid_out = 1'h0;
  end
  // One-cycle command; afterwards the lines carry the inverse so nothing stale looks valid
  task automatic send(input logic [2:0] sel, input logic [17:0] addr);
    @(posedge link_clk_in);
    mrs_out <= dtlc_mrs_t'({sel, addr});
    mrs_valid_out <= 1'h1;
    @(posedge link_clk_in);
    mrs_out <= dtlc_mrs_t'({~sel, ~addr});
    mrs_valid_out <= 1'h0;
  endtask : send
endmodule : dtlc_ctrl_model

// file: sim/dtlc_monitor.sv
// Checker on the top ports of the configuration block.
// Assumes the x16 default, so additive latency stays zero.
`timescale 1ns/100ps
module dtlc_monitor import dtlc_pkg::*; (
  input wire logic         clk_in,
  input wire logic         rst_n_in,
  input wire logic         ce_in,
  input wire logic         on_die_termination_control_in,
  input wire logic         write_active_in,
  input wire logic         cmd_valid_in,
  input wire logic         cmd_write_in,
  input wire logic         cmd_valid_out,
  input wire logic         cmd_write_out,
  input wire dtlc_status_t status_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic         tc;
  dtlc_source_t src;
  assign tc = on_die_termination_control_in;
  assign src = status_out.termination_source;
  property p_cmd; ce_in && cmd_valid_in |=> cmd_valid_out && cmd_write_out == $past(cmd_write_in);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command not passed on");
  property p_nospur; $past(rst_n_in) && !$past(cmd_valid_in) |-> !cmd_valid_out; endproperty
  a_nospur: assert property (p_nospur) else $error("late or stray command");
  property p_park; $past(rst_n_in) && !$past(tc) |-> src inside {DTLC_APPLY_NONE, DTLC_APPLY_PARK};
  endproperty
  a_park: assert property (p_park) else $error("park not applied");
  property p_parksrc; src == DTLC_APPLY_PARK |-> !$past(tc); endproperty
  a_parksrc: assert property (p_parksrc) else $error("park with control high");
  property p_wr; src == DTLC_APPLY_WR |-> $past(tc && write_active_in) && status_out.termination_code != 3'h0;
  endproperty
  a_wr: assert property (p_wr) else $error("write termination misapplied");
  property p_nowr; $past(rst_n_in) && $past(tc && !write_active_in) |-> src != DTLC_APPLY_WR; endproperty
  a_nowr: assert property (p_nowr) else $error("write termination outside write");
  property p_rl; status_out.read_latency_total inside {6'h00, 6'h09}; endproperty
  a_rl: assert property (p_rl) else $error("read latency wrong");
  property p_wl; status_out.write_latency_total inside {0, 9, 10, 11, 12, 14, 16, 18, 20};
  endproperty
  a_wl: assert property (p_wl) else $error("write latency wrong");
endmodule : dtlc_monitor
bind dtlc_top dtlc_monitor mon (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
  .on_die_termination_control_in(on_die_termination_control_in),
  .write_active_in(write_active_in), .cmd_valid_in(cmd_valid_in), .cmd_write_in(cmd_write_in),
  .cmd_valid_out(cmd_valid_out), .cmd_write_out(cmd_write_out), .status_out(status_out));

// file: src/dtlc_defines.svh
// Offsets, field positions and codes of the mode-register configuration block.
// Assumes inclusion by bare name from the package; the top module does not include it.
`ifndef DTLC_DEFINES_SVH
`define DTLC_DEFINES_SVH

// Mode register select codes on {bank group, bank address 1, bank address 0}
`define DTLC_SEL_DRIVE     3'b001
`define DTLC_SEL_WRLAT     3'b010
`define DTLC_SEL_PARK      3'b101

// Drive configuration register fields
`define DTLC_DRV_IMP_LSB   1
`define DTLC_DRV_AL_LSB    3
`define DTLC_DRV_WLEV_BIT  7
`define DTLC_DRV_NOM_LSB   8
`define DTLC_DRV_QOFF_BIT  12

// Write latency configuration register fields
`define DTLC_WR_CWL_LSB    3
`define DTLC_WR_LOW_POWER_SELF_REFRESH_RANGE_LSB  6
`define DTLC_WR_TERM_LSB   9
`define DTLC_WR_CRC_BIT    12

// Park configuration register field
`define DTLC_PARK_LSB      6

// Reset values
`define DTLC_ADDR_RESET    18'h0_0000

// Write termination field codes
`define DTLC_WT_OFF        3'h0
`define DTLC_WT_DIV2       3'h1
`define DTLC_WT_DIV1       3'h2
`define DTLC_WT_HIZ        3'h3
`define DTLC_WT_DIV3       3'h4

// Additive latency codes: 0, read column latency minus 1, read column latency minus 2
`define DTLC_AL_ZERO       2'h0
`define DTLC_AL_M1         2'h1
`define DTLC_AL_M2         2'h2

`endif

// file: src/dtlc_pkg.sv
// Types shared by the mode-register configuration block.
// Assumes the defines header is on the include path.
package dtlc_pkg;
  `include "dtlc_defines.svh"

  typedef enum logic [2:0] {
    DTLC_TERM_OFF  = 3'b000,
    DTLC_TERM_DIV2 = 3'b001,
    DTLC_TERM_DIV1 = 3'b010,
    DTLC_TERM_HIZ  = 3'b011,
    DTLC_TERM_DIV3 = 3'b100,
    DTLC_TERM_RSVD = 3'b111
  } dtlc_wterm_t;

  typedef enum logic [1:0] {
    DTLC_APPLY_NONE = 2'b00,
    DTLC_APPLY_PARK = 2'b01,
    DTLC_APPLY_NOM  = 2'b10,
    DTLC_APPLY_WR   = 2'b11
  } dtlc_source_t;

  // One mode register set command as seen at the link
  typedef struct packed {
    logic [2:0]  sel;
    logic [17:0] addr;
  } dtlc_mrs_t;

  // Settings that steer the data path
  typedef struct packed {
    logic [1:0]  drive_imp;
    logic [2:0]  termination_code;
    dtlc_source_t termination_source;
    logic        outputs_off;
    logic        leveling_on;
    logic        write_crc_on;
    logic [1:0]  low_power_self_refresh_range;
    logic [5:0]  read_latency_total;
    logic [5:0]  write_latency_total;
  } dtlc_status_t;
endpackage : dtlc_pkg

// file: src/dtlc_top.sv
// Mode-register configuration for driver, termination and latency.
// Assumes MRS commands arrive on the link clock; settings are used on clk_in.
// Function
// - Driver impedance from drive register bits 2:1
// - Hold nominal, write and park termination
// - Write termination applies even with nominal off
// - Park termination applies while termination input low
// - Delay read/write command by additive latency
// - Read latency is additive plus read column
// - Write latency is additive plus parity plus write column
// - Wide x16 organisation forces additive latency zero
// - Provide write leveling mode
// - Output disable bit disconnects data and strobes
// - Write column latency bits 5:3, adds parity
`timescale 1ns/100ps
module dtlc_top #(
  parameter int          READ_COL_LAT = 9,
  parameter int          PAR_LAT      = 0,
  parameter bit          WIDE_X16     = 1'b1
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  ce_in,
  input  wire logic                  link_clk_in,
  input  wire logic                  link_rst_n_in,
  input  wire dtlc_pkg::dtlc_mrs_t   mrs_in,
  input  wire logic                  mrs_valid_in,
  input  wire logic                  on_die_termination_control_in,
  input  wire logic                  write_active_in,
  input  wire logic                  cmd_valid_in,
  input  wire logic                  cmd_write_in,
  output logic                       cmd_valid_out,
  output logic                       cmd_write_out,
  output dtlc_pkg::dtlc_status_t     status_out
);
  import dtlc_pkg::*;

  // Elaboration check: the largest additive latency must index the
  // 32-stage delay line, and the latency sums must fit six-bit fields.
  // Worst case is 30 + 31 for read and 30 + 8 + 20 for write.
  if (READ_COL_LAT < 2 || READ_COL_LAT > 31 || PAR_LAT < 0 || PAR_LAT > 8) begin : g_bad_lat
    $error("dtlc_top: latency parameter out of range");
  end

  // Six-bit copies of the latency parameters for the sums below
  localparam logic [5:0] RCL = 6'(READ_COL_LAT);
  localparam logic [5:0] PLL = 6'(PAR_LAT);

  // --------------------------------------------------------------------
  // The block has two halves. The link half captures each write to the
  // drive, write latency and park registers on the controller's clock. The core half copies the captured
  // words once a toggle has crossed, decodes the fields and steers the
  // termination choice and the command delay line.
  // --------------------------------------------------------------------

  // Link domain: capture of mode register writes
  // Each register keeps its whole address word; fields are cut out later
  // in the core domain, so reserved bits are stored but never used.
  logic [17:0] drive_config_register_q;
  logic [17:0] write_latency_config_register_q;
  logic [17:0] park_config_register_q;
  logic        link_tog_q;

  wire sel_drive = mrs_valid_in && (mrs_in.sel == `DTLC_SEL_DRIVE);
  wire sel_wrlat = mrs_valid_in && (mrs_in.sel == `DTLC_SEL_WRLAT);
  wire sel_park  = mrs_valid_in && (mrs_in.sel == `DTLC_SEL_PARK);

  // Select codes other than the three above are ignored: the block does
  // not model the remaining mode registers.

  always_ff @(posedge link_clk_in) begin
    if (!link_rst_n_in) begin
      drive_config_register_q         <= `DTLC_ADDR_RESET;
      write_latency_config_register_q <= `DTLC_ADDR_RESET;
      park_config_register_q          <= `DTLC_ADDR_RESET;
      link_tog_q                      <= 1'b0;
    end else begin
      if (sel_drive) drive_config_register_q <= mrs_in.addr;
      if (sel_wrlat) write_latency_config_register_q <= mrs_in.addr;
      if (sel_park)  park_config_register_q <= mrs_in.addr;
      if (sel_drive || sel_wrlat || sel_park) link_tog_q <= ~link_tog_q;
    end
  end

  // Toggle handshake: registers are stable once the toggle has been seen here,
  // since the controller leaves MRS spacing far above two local cycles.
  // Limitation: two writes closer than the crossing time collapse into
  // one update; the later word wins, which is what the controller meant.
  logic [2:0]  tog_sync_q;
  logic [17:0] drv_q;
  logic [17:0] wrl_q;
  logic [17:0] prk_q;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tog_sync_q <= 3'b000;
      drv_q      <= `DTLC_ADDR_RESET;
      wrl_q      <= `DTLC_ADDR_RESET;
      prk_q      <= `DTLC_ADDR_RESET;
    end else if (ce_in) begin
      // Stages 0 and 1 synchronise; stage 2 only marks the edge
      tog_sync_q <= {tog_sync_q[1:0], link_tog_q};
      if (tog_sync_q[2] != tog_sync_q[1]) begin
        drv_q <= drive_config_register_q;
        wrl_q <= write_latency_config_register_q;
        prk_q <= park_config_register_q;
      end
    end
  end


  // Field decode
  // All fields come from the core-domain copies, never from the link
  // registers, so a write in flight cannot tear a decoded value.
  wire [1:0] drive_imp  = drv_q[`DTLC_DRV_IMP_LSB +: 2];
  wire [2:0] nominal_termination = drv_q[`DTLC_DRV_NOM_LSB +: 3];
  wire [2:0] write_termination   = wrl_q[`DTLC_WR_TERM_LSB +: 3];
  wire [2:0] park_termination    = prk_q[`DTLC_PARK_LSB +: 3];
  wire [1:0] al_code    = WIDE_X16 ? `DTLC_AL_ZERO : drv_q[`DTLC_DRV_AL_LSB +: 2];
  wire [2:0] cwl_code   = wrl_q[`DTLC_WR_CWL_LSB +: 3];


  // Write column latency table: 9,10,11,12,14,16,18,20
  // Low codes step by one from 9; high codes step by two from 14.
  wire [5:0] write_column_latency = (cwl_code < 3'h4) ? 6'(cwl_code) + 6'd9
                                  : 6'd14 + {2'b00, cwl_code[1:0], 1'b0, 1'b0} / 6'd2;


  // Additive latency follows the read column latency; code 3 is
  // reserved and is treated as zero.
  wire [5:0] additive_latency = (al_code == `DTLC_AL_M1) ? RCL - 6'd1 :
                                (al_code == `DTLC_AL_M2) ? RCL - 6'd2 : 6'd0;


  // Totals reported to the data path; no half-cycle latencies exist
  wire [5:0] rl_d = additive_latency + RCL;
  wire [5:0] wl_d = additive_latency + PLL + write_column_latency;


  // Write termination decode; reserved codes treated as off
  // Hi-Z is a real setting, so it counts as enabled below.
  dtlc_wterm_t wterm;
  assign wterm = (write_termination == `DTLC_WT_DIV2) ? DTLC_TERM_DIV2 :
                 (write_termination == `DTLC_WT_DIV1) ? DTLC_TERM_DIV1 :
                 (write_termination == `DTLC_WT_HIZ)  ? DTLC_TERM_HIZ  :
                 (write_termination == `DTLC_WT_DIV3) ? DTLC_TERM_DIV3 : DTLC_TERM_OFF;

  wire wr_term_on = (wterm != DTLC_TERM_OFF);
  wire odt_hi     = on_die_termination_control_in;


  // Priority: write termination during writes regardless of nominal setting
  // The control level comes from core-clock logic, so it is used as is.
  dtlc_source_t src;
  assign src = (odt_hi && write_active_in && wr_term_on)    ? DTLC_APPLY_WR   :
               (odt_hi && nominal_termination != 3'h0)      ? DTLC_APPLY_NOM  :
               (!odt_hi && park_termination != 3'h0)        ? DTLC_APPLY_PARK :
                                                              DTLC_APPLY_NONE;
  wire [2:0] term_code = (src == DTLC_APPLY_WR)   ? write_termination :
                         (src == DTLC_APPLY_NOM)  ? nominal_termination :
                         (src == DTLC_APPLY_PARK) ? park_termination : 3'h0;


  // Additive-latency delay line for issued commands
  // Trade-off: a plain shift register costs 64 flops but needs no counter
  // per command, so back-to-back commands after activate are never lost.
  logic [31:0] dly_v_q;
  logic [31:0] dly_w_q;
  wire  [4:0]  al_idx = additive_latency[4:0];

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dly_v_q <= 32'h0000_0000;
      dly_w_q <= 32'h0000_0000;
    end else if (ce_in) begin
      dly_v_q <= {dly_v_q[30:0], cmd_valid_in && cmd_valid_in};
      dly_w_q <= {dly_w_q[30:0], cmd_write_in};
    end
  end


  // With no additive latency the command bypasses the delay line
  wire cmd_v_sel = (al_idx == 5'd0) ? cmd_valid_in : dly_v_q[al_idx - 5'd1];
  wire cmd_w_sel = (al_idx == 5'd0) ? cmd_write_in : dly_w_q[al_idx - 5'd1];


  // Every output is a flop; status follows the copies one cycle later
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cmd_valid_out <= 1'b0;
      cmd_write_out <= 1'b0;
      status_out    <= '0;
    end else if (ce_in) begin
      // The write flag is qualified so a stale flag never leaks out
      cmd_valid_out <= cmd_v_sel;
      cmd_write_out <= cmd_w_sel && cmd_v_sel;
      status_out.drive_imp          <= drive_imp;
      status_out.termination_code   <= term_code;
      status_out.termination_source <= src;
      status_out.outputs_off        <= drv_q[`DTLC_DRV_QOFF_BIT];
      status_out.leveling_on        <= drv_q[`DTLC_DRV_WLEV_BIT];
      status_out.write_crc_on       <= wrl_q[`DTLC_WR_CRC_BIT];
      status_out.low_power_self_refresh_range <= wrl_q[`DTLC_WR_LOW_POWER_SELF_REFRESH_RANGE_LSB +: 2];
      status_out.read_latency_total  <= rl_d;
      status_out.write_latency_total <= wl_d;
    end
  end
endmodule : dtlc_top
